/* hdl/ths_defines.vh */
/*
 * Constants for the track/hold conversion sequencer: timing figures, derived cycle counts,
 * register offsets and field positions.
 * Assumes a 20 MHz system clock and inclusion by bare name from the design files.
 */
`ifndef THS_DEFINES_VH
`define THS_DEFINES_VH

`define THS_CLK_MHZ        20
// Times in nanoseconds, as printed.
`define THS_T_CONV12_NS    6400
`define THS_T_CONV8_NS     4400
`define THS_T_ACQ_NS       1400
`define THS_T_APER_NS      20
`define THS_T_THRU12_NS    8500
`define THS_T_THRU8_NS     6300
// Cycle counts: typical figures rounded down, aperture rounded up to at least one cycle.
`define THS_CONV12_CYC     ((`THS_T_CONV12_NS * `THS_CLK_MHZ) / 1000)
`define THS_CONV8_CYC      ((`THS_T_CONV8_NS * `THS_CLK_MHZ) / 1000)
`define THS_ACQ_CYC        ((`THS_T_ACQ_NS * `THS_CLK_MHZ) / 1000)
`define THS_APER_CYC       (((`THS_T_APER_NS * `THS_CLK_MHZ) + 999) / 1000)

`define THS_RES_W          12
`define THS_CNT_W          8

// Register port offsets.
`define THS_REG_STATUS     4'h0
`define THS_REG_MASK       4'h1
`define THS_REG_RESULT     4'h2
`define THS_REG_STATE      4'h3
// Interrupt status fields.
`define THS_IRQ_DONE       0
`define THS_IRQ_IGNORED    1
`define THS_IRQ_READY      2
`define THS_IRQ_W          3
`define THS_MASK_RST       3'h0

`endif

/* hdl/ths_sync.v */
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes the inputs are asynchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ths_sync #(
  parameter W = 5
) (
  input  wire         i_clk,
  input  wire         i_rstn,
  input  wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule // ths_sync
`default_nettype wire

/* hdl/ths_counter.v */
/*
 * Loadable down counter that reports the cycle in which it reaches one.
 * Assumes the load value is at least one.
 */
`timescale 1ns/1ps
`default_nettype none
module ths_counter #(
  parameter W = 8
) (
  input  wire         i_clk,
  input  wire         i_rstn,
  input  wire         i_load,
  input  wire [W-1:0] i_value,
  output wire         o_last,
  output wire         o_busy
);
  reg [W-1:0] cnt_ff;

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_ff <= {W{1'b0}};
    end else if (i_load) begin
      cnt_ff <= i_value;
    end else if (cnt_ff != {W{1'b0}}) begin
      cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign o_last = (cnt_ff == {{(W-1){1'b0}}, 1'b1}) && !i_load;
  assign o_busy = (cnt_ff != {W{1'b0}});
endmodule // ths_counter
`default_nettype wire

/* hdl/ths_sequencer.v */
/*
 * Track/hold conversion sequencer: start detection on the control pins, aperture
 * delay, timed conversion, acquisition interval, three-state result output and a small
 * register port with a sticky interrupt.
 * Assumes control pins are asynchronous and the converter core supplies its result
 * bits while in conversion; the result is captured at the end of conversion.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ths_defines.vh"
module ths_sequencer #(
  parameter CONV12_CYC = `THS_CONV12_CYC,
  parameter CONV8_CYC  = `THS_CONV8_CYC,
  parameter ACQ_CYC    = `THS_ACQ_CYC,
  parameter APER_CYC   = `THS_APER_CYC
) (
  input  wire                  i_clk,
  input  wire                  i_rstn,
  input  wire                  i_chip_enable,
  input  wire                  i_select_n,
  input  wire                  i_read_convert,
  input  wire                  i_byte_select_short_cycle,
  input  wire                  i_wide_output,
  input  wire [`THS_RES_W-1:0] i_core_result,
  input  wire [3:0]            i_addr,
  input  wire [7:0]            i_wdata,
  input  wire                  i_wr,
  input  wire                  i_rd,
  output reg  [7:0]            o_rdata,
  output reg  [`THS_RES_W-1:0] o_result_bits,
  output reg  [`THS_RES_W-1:0] o_result_bits_oe,
  output reg                   o_conversion_in_progress_flag,
  output reg                   o_hold,
  output reg                   o_irq
);
  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  localparam [3:0] ST_TRACK = 4'b0001;
  localparam [3:0] ST_APER  = 4'b0010;
  localparam [3:0] ST_CONV  = 4'b0100;
  localparam [3:0] ST_ACQ   = 4'b1000;

  localparam [`THS_CNT_W-1:0] CONV12_V = CONV12_CYC[`THS_CNT_W-1:0];
  localparam [`THS_CNT_W-1:0] CONV8_V  = CONV8_CYC[`THS_CNT_W-1:0];
  localparam [`THS_CNT_W-1:0] ACQ_V    = ACQ_CYC[`THS_CNT_W-1:0];
  localparam [`THS_CNT_W-1:0] APER_V   = APER_CYC[`THS_CNT_W-1:0];

  // ****************************************************************
  // Pin synchronisation and start detection
  // ****************************************************************
  wire [4:0] pins_s;
  ths_sync #(.W(5)) u_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    ({i_wide_output, i_byte_select_short_cycle, i_read_convert,
              i_select_n, i_chip_enable}),
    .o_q    (pins_s)
  );

  wire ce_s   = pins_s[0];
  wire csn_s  = pins_s[1];
  wire rc_s   = pins_s[2];
  wire ao_s   = pins_s[3];
  wire wide_s = pins_s[4];

  reg  start_cond_ff;
  reg  [3:0] state_ff;
  reg  [3:0] nxt_state;
  reg  short_ff;
  reg  [`THS_RES_W-1:0] result_ff;
  reg  [`THS_IRQ_W-1:0] status_ff;
  reg  [`THS_IRQ_W-1:0] mask_ff;

  // Start condition is the conjunction; its rising edge marks the last input to arrive.
  wire start_cond = ce_s && !csn_s && !rc_s;
  wire start_req  = start_cond && !start_cond_ff;
  wire busy       = (state_ff == ST_APER) || (state_ff == ST_CONV);
  wire accept     = start_req && (state_ff == ST_TRACK);
  wire ignored    = start_req && !accept;

  // ****************************************************************
  // Interval counters
  // ****************************************************************
  wire ld_aper = accept;
  wire ld_conv;
  wire ld_acq;
  wire aper_last;
  wire conv_last;
  wire acq_last;
  reg  [`THS_CNT_W-1:0] conv_len;

  always @* begin
    conv_len = short_ff ? CONV8_V : CONV12_V;
  end

  ths_counter #(.W(`THS_CNT_W)) u_aper (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (ld_aper),
    .i_value (APER_V),
    .o_last  (aper_last),
    .o_busy  ()
  );

  ths_counter #(.W(`THS_CNT_W)) u_conv (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (ld_conv),
    .i_value (conv_len),
    .o_last  (conv_last),
    .o_busy  ()
  );

  ths_counter #(.W(`THS_CNT_W)) u_acq (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (ld_acq),
    .i_value (ACQ_V),
    .o_last  (acq_last),
    .o_busy  ()
  );

  // Aperture then conversion, then acquisition; counters give the timing.
  assign ld_conv = (state_ff == ST_APER) && aper_last;
  assign ld_acq  = (state_ff == ST_CONV) && conv_last;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_TRACK: begin
        if (accept) begin
          nxt_state = ST_APER;
        end
      end
      ST_APER: begin
        if (aper_last) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_last) begin
          nxt_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        // Tracking continues; a start during acquisition is ignored, and tracking resumes after the full interval.
        if (acq_last) begin
          nxt_state = ST_TRACK;
        end
      end
      default: begin
        nxt_state = ST_TRACK;
      end
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      state_ff      <= ST_TRACK;
      start_cond_ff <= 1'b0;
      short_ff      <= 1'b0;
      result_ff     <= {`THS_RES_W{1'b0}};
    end else begin
      state_ff      <= nxt_state;
      start_cond_ff <= start_cond;
      if (accept) begin
        short_ff <= ao_s;
      end
      if (ld_acq) begin
        // Short conversions leave the three lowest bits clear and the next one set.
        result_ff <= short_ff ? {i_core_result[11:4], 4'h8} : i_core_result;
      end
    end
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  wire rd_en   = rc_s && !busy && ce_s && !csn_s;
  reg  [`THS_RES_W-1:0] nxt_oe;
  reg  [`THS_RES_W-1:0] nxt_bits;

  always @* begin
    nxt_oe   = {`THS_RES_W{1'b0}};
    nxt_bits = result_ff;
    if (rd_en) begin
      if (wide_s) begin
        nxt_oe = {`THS_RES_W{1'b1}};
      end else if (!ao_s) begin
        nxt_oe = 12'hff0;
      end else begin
        // Upper nibble off, middle lines driven low, low nibble on the low lines.
        nxt_oe   = 12'h0ff;
        nxt_bits = {result_ff[11:8], 4'h0, result_ff[3:0]};
      end
    end
  end

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_result_bits                 <= {`THS_RES_W{1'b0}};
      o_result_bits_oe              <= {`THS_RES_W{1'b0}};
      o_conversion_in_progress_flag <= 1'b0;
      o_hold                        <= 1'b0;
    end else begin
      o_result_bits                 <= nxt_bits;
      o_result_bits_oe              <= (nxt_state == ST_APER || nxt_state == ST_CONV)
                                       ? {`THS_RES_W{1'b0}} : nxt_oe;
      o_conversion_in_progress_flag <= (nxt_state == ST_APER) ||
                                       (nxt_state == ST_CONV);
      o_hold                        <= (nxt_state == ST_CONV);
    end
  end

  // ****************************************************************
  // Register port and interrupt
  // ****************************************************************
  wire [`THS_IRQ_W-1:0] events = {rd_en && (state_ff == ST_TRACK), ignored, ld_acq};
  wire rd_status = i_rd && (i_addr == `THS_REG_STATUS);

  always @(posedge i_clk) begin
    if (!i_rstn) begin
      status_ff <= {`THS_IRQ_W{1'b0}};
      mask_ff   <= `THS_MASK_RST;
      o_rdata   <= 8'h00;
      o_irq     <= 1'b0;
    end else begin
      // A new event in the clearing read survives the clear.
      status_ff <= (rd_status ? {`THS_IRQ_W{1'b0}} : status_ff) | events;
      if (i_wr && (i_addr == `THS_REG_MASK)) begin
        mask_ff <= i_wdata[`THS_IRQ_W-1:0];
      end
      if (!i_rd) begin
        o_rdata <= 8'h00;
      end else if (i_addr == `THS_REG_STATUS) begin
        o_rdata <= {5'h00, status_ff};
      end else if (i_addr == `THS_REG_MASK) begin
        o_rdata <= {5'h00, mask_ff};
      end else if (i_addr == `THS_REG_RESULT) begin
        o_rdata <= result_ff[11:4];
      end else if (i_addr == `THS_REG_STATE) begin
        o_rdata <= {result_ff[3:0], short_ff, busy, state_ff == ST_ACQ, state_ff == ST_TRACK};
      end else begin
        o_rdata <= 8'h00;
      end
      o_irq <= |(((rd_status ? {`THS_IRQ_W{1'b0}} : status_ff) | events) & mask_ff);
    end
  end
endmodule // ths_sequencer
`default_nettype wire

/* dv/ths_seq_asserts.sv */
/* Pin checker for the track/hold sequencer.
   Assumes it is bound to ths_sequencer and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ths_seq_asserts #(
  parameter CONV12_CYC = 128,
  parameter CONV8_CYC  = 88,
  parameter ACQ_CYC    = 28,
  parameter APER_CYC   = 1
) (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_read_convert,
  input wire logic        i_byte_select_short_cycle,
  input wire logic [11:0] o_result_bits_oe,
  input wire logic        o_conversion_in_progress_flag,
  input wire logic        o_hold,
  input wire logic        o_irq
);
  localparam logic [7:0] RUN12 = 8'(APER_CYC + CONV12_CYC);
  localparam logic [7:0] RUN8  = 8'(APER_CYC + CONV8_CYC);
  logic [7:0] run_ff;
  logic [7:0] gap_ff;
  logic       short_ff;
  wire        flag = o_conversion_in_progress_flag;
  wire [11:0] oe   = o_result_bits_oe;
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      run_ff   <= 8'h00;
      gap_ff   <= 8'hff;
      short_ff <= 1'b0;
    end else begin
      run_ff <= flag ? run_ff + 8'h01 : 8'h00;
      if (flag) gap_ff <= 8'h00;
      else if (gap_ff != 8'hff) gap_ff <= gap_ff + 8'h01;
      if (!flag) short_ff <= i_byte_select_short_cycle;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_hold_after_start: assert property ($rose(flag) |=> o_hold)
    else $error("hold not entered after start");
  a_hold_in_conv: assert property (o_hold |-> flag)
    else $error("hold outside conversion");
  a_track_at_end: assert property ($fell(flag) |-> !o_hold)
    else $error("hold kept after conversion");
  a_conv_length: assert property ($fell(flag) |-> run_ff == (short_ff ? RUN8 : RUN12))
    else $error("wrong conversion length");
  a_acq_spacing: assert property ($rose(flag) |-> gap_ff >= ACQ_CYC)
    else $error("start inside acquisition");
  a_busy_no_oe: assert property (flag |-> oe == 12'h000)
    else $error("lines driven while busy");
  a_convert_no_oe: assert property (!i_read_convert [*5] |-> oe == 12'h000)
    else $error("lines driven in convert mode");
  a_oe_layout: assert property (oe inside {12'h000, 12'hff0, 12'h0ff, 12'hfff})
    else $error("bad line enable pattern");
  a_start_cmd: assert property ($rose(flag) |-> !$past(i_read_convert, 3))
    else $error("start without convert command");
  c_short: cover property ($fell(flag) && short_ff);
  c_long: cover property ($fell(flag) && !short_ff);
  c_irq: cover property ($rose(o_irq));
endmodule // ths_seq_asserts
bind ths_sequencer ths_seq_asserts #(.CONV12_CYC(CONV12_CYC), .CONV8_CYC(CONV8_CYC),
  .ACQ_CYC(ACQ_CYC), .APER_CYC(APER_CYC)) u_chk (.i_clk, .i_rstn, .i_read_convert,
  .i_byte_select_short_cycle, .o_result_bits_oe, .o_conversion_in_progress_flag,
  .o_hold, .o_irq);
`default_nettype wire

/* dv/ths_host_model.sv */
/* Host model driving the sequencer's control pins.
   Assumes its tasks are called from one bench process. */
`timescale 1ns/1ps
`default_nettype none
module ths_host_model (
  input  wire logic i_clk,
  output logic o_ce    = 1'b1,
  output logic o_sel_n = 1'b0,
  output logic o_rc    = 1'b1,
  output logic o_short = 1'b0,
  output logic o_wide  = 1'b1
);
  // The pin chosen by via arrives last and starts the conversion.
  task automatic convert(input logic s, input logic [1:0] via);
    @(posedge i_clk);
    o_short <= s;
    o_rc    <= 1'b0;
    o_ce    <= (via != 2'h1);
    o_sel_n <= (via == 2'h2);
    if (via != 2'h0) begin
      repeat (3) @(posedge i_clk);
      o_ce    <= 1'b1;
      o_sel_n <= 1'b0;
    end
    repeat (6) @(posedge i_clk);
    o_rc <= 1'b1;
  endtask
  task automatic read_mode(input logic w, input logic a);
    @(posedge i_clk);
    o_wide  <= w;
    o_short <= a;
  endtask
endmodule // ths_host_model
`default_nettype wire

/* dv/testbench.sv */
/* Bench for the sequencer: both lengths, all start pins, refused starts, result
   layouts, register port and interrupt. Assumes the host model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int C12 = 128;
  localparam int C8  = 88;
  logic        i_clk, i_rstn, i_wr, i_rd, flag_q;
  logic [3:0]  i_addr;
  logic [7:0]  i_wdata, rd_v;
  logic [11:0] core;
  int          num_errors, n_tests, run_len;
  wire  [7:0]  o_rdata;
  wire  [11:0] bits, oe;
  wire         flag, hold, irq, ce, sel_n, rc, sh, wide;
  ths_host_model host (.i_clk, .o_ce(ce), .o_sel_n(sel_n), .o_rc(rc), .o_short(sh),
    .o_wide(wide));
  ths_sequencer #(.CONV12_CYC(C12), .CONV8_CYC(C8), .ACQ_CYC(28), .APER_CYC(1)) DUT (
    .i_clk, .i_rstn, .i_chip_enable(ce), .i_select_n(sel_n), .i_read_convert(rc),
    .i_byte_select_short_cycle(sh), .i_wide_output(wide), .i_core_result(core),
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_result_bits(bits), .o_result_bits_oe(oe),
    .o_conversion_in_progress_flag(flag), .o_hold(hold), .o_irq(irq));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    flag_q  <= flag;
    run_len <= flag ? (flag_q ? run_len + 1 : 1) : run_len;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_v = o_rdata;
  endtask
  task automatic wait_end;
    int k;
    k = 0;
    while (flag !== 1'b0 && k < 400) begin
      settle(1);
      k++;
    end
    if (k == 400) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic t_conv(input logic s, input logic [1:0] via);
    logic [11:0] exp;
    exp = s ? {core[11:4], 4'h8} : core;
    host.convert(s, via);
    wait_end();
    chk(12'(run_len), 12'(s ? C8 + 1 : C12 + 1));
    host.read_mode(1'b1, 1'b0);
    settle(5);
    chk(oe, 12'hfff);
    chk(bits, exp);
    host.read_mode(1'b0, 1'b0);
    settle(5);
    chk(oe, 12'hff0);
    chk(bits & oe, {exp[11:4], 4'h0});
    host.read_mode(1'b0, 1'b1);
    settle(5);
    chk(oe, 12'h0ff);
    chk(bits & oe, {8'h00, exp[3:0]});
    settle(30);
    $display("conversion test done: short %0d via %0d", s, via);
  endtask
  task automatic t_refuse;
    reg_rd(4'h0);
    host.convert(1'b0, 2'h0);
    settle(20);
    host.convert(1'b1, 2'h0);
    wait_end();
    chk(12'(run_len), 12'(C12 + 1));
    reg_rd(4'h0);
    chk({4'h0, rd_v & 8'h03}, 12'h003);
    host.convert(1'b0, 2'h0);
    settle(10);
    chk({11'h0, flag}, 12'h000);
    settle(40);
    host.convert(1'b0, 2'h0);
    wait_end();
    chk(12'(run_len), 12'(C12 + 1));
    settle(30);
    $display("refused start test done");
  endtask
  task automatic t_irq;
    reg_wr(4'h1, 8'h01);
    reg_rd(4'h1);
    chk({4'h0, rd_v}, 12'h001);
    reg_rd(4'hf);
    chk({4'h0, rd_v}, 12'h000);
    reg_rd(4'h0);
    host.convert(1'b1, 2'h1);
    wait_end();
    settle(2);
    chk({11'h0, irq}, 12'h001);
    reg_rd(4'h0);
    chk({4'h0, rd_v & 8'h01}, 12'h001);
    settle(2);
    chk({11'h0, irq}, 12'h000);
    reg_rd(4'h2);
    chk({4'h0, rd_v}, {4'h0, core[11:4]});
    settle(30);
    reg_rd(4'h3);
    chk({4'h0, rd_v}, 12'h089);
    $display("interrupt test done");
  endtask
  initial begin
    i_rstn  = 1'b0;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    i_addr  = 4'h0;
    i_wdata = 8'h00;
    core    = 12'ha5c;
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    settle(4);
    chk({9'h0, flag, hold, irq}, 12'h000);
    for (int v = 0; v < 3; v++) begin
      t_conv(1'b0, 2'(v));
      t_conv(1'b1, 2'(v));
    end
    t_refuse();
    t_irq();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
